// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import uie_pkg::*;
   logic        mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0, cts_in = 1'b0, rts_in = 1'b0;
   logic        wake_in = 1'b0, bit_tick_in = 1'b0;
   logic        dsr_in = 1'b0, dtr_in = 1'b0;
   logic [3:0]  reg_addr_in = 4'h0, msr_delta_in = 4'h0;
   logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out;
   logic        irq_out, wake_irq_out;
   uie_rx_t     rx = '0;
   uie_tx_t     tx = '0;
   uie_flow_t   flow = '0;
   uie_acc_t    acc = '0;
   int          bad_count = 0, comparisons = 0, cycles = 0;
   uie_top u_dut (.mclk_in, .rst_n_in, .clk_en_in(1'b1), .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_in(rx),
      .tx_in(tx), .flow_in(flow), .acc_in(acc), .msr_delta_in, .cts_in,
      .dsr_in, .rts_in, .dtr_in, .wake_in, .bit_tick_in,
      .word_len_in(2'h0), .irq_out, .wake_irq_out, .fifo_en_out());
   initial forever #10 mclk_in = ~mclk_in;
   task automatic results;
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask : rd
   // Access pulses from the surrounding decoder, one cycle each
   task automatic pa(input uie_acc_t v);
      @(posedge mclk_in);
      acc <= v;
      @(posedge mclk_in);
      acc <= '0;
   endtask : pa
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      tx.level = 9'h005;
      tx.trig = 9'h004;
      cyc(6);
      rst_n_in <= 1'b1;
      rd(OFS_IER, 8'h00);
      rd(OFS_ISR, 8'h01);
      rd(4'hF, 8'h00);
      wr(OFS_CFG, 8'h01);
      rd(OFS_ISR, 8'hC1);
      rx.level <= 9'h004;
      rx.trig <= 9'h004;
      rx.head_err <= 3'h2;
      rx.any_err <= 1'b1;
      wr(OFS_IER, 8'h05);
      rd(OFS_ISR, 8'hC4);
      rx.push <= 1'b1;
      rx.push_err <= 1'b1;
      cyc(1);
      rx.push <= 1'b0;
      rx.push_err <= 1'b0;
      rd(OFS_ISR, 8'hC6);
      rd(OFS_LSR, 8'h89);
      rd(OFS_ISR, 8'hC4);
      rx.pop <= 1'b1;
      cyc(1);
      rx.pop <= 1'b0;
      rd(OFS_ISR, 8'hC6);
      rd(OFS_LSR, 8'h89);
      rd(OFS_ISR, 8'hC4);
      rx.level <= 9'h003;
      cyc(2);
      rd(OFS_ISR, 8'hC1);
      wr(OFS_IER, 8'h02);
      pa(4'h2);
      rd(OFS_ISR, 8'hC1);
      tx.level <= 9'h003;
      cyc(2);
      rd(OFS_ISR, 8'hC2);
      rd(OFS_ISR, 8'hC1);
      tx.level <= 9'h000;
      cyc(2);
      rd(OFS_ISR, 8'hC2);
      rd(OFS_ISR, 8'hC1);
      wr(OFS_IER, 8'h08);
      msr_delta_in <= 4'h1;
      cyc(2);
      rd(OFS_ISR, 8'hC0);
      msr_delta_in <= 4'h0;
      rd(OFS_ISR, 8'hC1);
      wr(OFS_CFG, 8'h03);
      wr(OFS_IER, 8'h20);
      flow.xoff <= 1'b1;
      cyc(1);
      flow.xoff <= 1'b0;
      rd(OFS_ISR, 8'hD0);
      rd(OFS_ISR, 8'hC1);
      wr(OFS_IER, 8'hC0);
      cts_in <= 1'b1;
      cyc(2);
      rd(OFS_ISR, 8'hE0);
      pa(4'h8);
      rd(OFS_ISR, 8'hC1);
      rts_in <= 1'b1;
      cyc(2);
      rd(OFS_ISR, 8'hE0);
      pa(4'h8);
      wr(OFS_CFG, 8'h1D);
      dsr_in <= 1'b1;
      cyc(2);
      rd(OFS_ISR, 8'hE0);
      pa(4'h8);
      dtr_in <= 1'b1;
      cyc(2);
      rd(OFS_ISR, 8'hE0);
      pa(4'h8);
      wr(OFS_IER, 8'h00);
      wake_in <= 1'b1;
      cyc(1);
      wake_in <= 1'b0;
      #1 chk({7'h00, wake_irq_out}, 8'h01);
      pa(4'h1);
      #1 chk({7'h00, irq_out}, 8'h00);
      wr(OFS_IER, 8'h01);
      rx.level <= 9'h001;
      rx.push <= 1'b1;
      cyc(1);
      rx.push <= 1'b0;
      bit_tick_in <= 1'b1;
      cyc(30);
      bit_tick_in <= 1'b0;
      rd(OFS_ISR, 8'hC1);
      bit_tick_in <= 1'b1;
      cyc(14);
      bit_tick_in <= 1'b0;
      rd(OFS_ISR, 8'hCC);
      pa(4'h4);
      rd(OFS_ISR, 8'hC1);
      results();
   end
endmodule : testbench
`default_nettype wire

// [sim/uie_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module uie_top_chk (
   input wire logic                       mclk_in,
   input wire logic                       rst_n_in,
   input wire logic                       clk_en_in,
   input wire logic [uie_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [uie_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic                       reg_wr_in,
   input wire logic                       reg_rd_in,
   input wire logic [uie_pkg::DATA_W-1:0] reg_rdata_out,
   input wire uie_pkg::uie_rx_t           rx_in,
   input wire uie_pkg::uie_tx_t           tx_in,
   input wire logic [3:0]                 msr_delta_in,
   input wire logic                       wake_in,
   input wire logic                       irq_out,
   input wire logic                       wake_irq_out,
   input wire logic                       fifo_en_out
);
   import uie_pkg::*;
   logic [7:0] ier_q;
   logic       rd_isr;
   logic       rd_lsr;
   assign rd_isr = reg_rd_in && clk_en_in && reg_addr_in == OFS_ISR;
   assign rd_lsr = reg_rd_in && clk_en_in && reg_addr_in == OFS_LSR;
   // Shadow of the enables, since only the ports are visible
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) ier_q <= IER_RST;
      else if (clk_en_in && reg_wr_in && reg_addr_in == OFS_IER)
         ier_q <= reg_wdata_in;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_rd_idle;
      $past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == RD_ZERO;
   endproperty
   property p_isr_fifo;
      $past(rd_isr) |-> reg_rdata_out[7:6] == {2{$past(fifo_en_out)}};
   endproperty
   property p_isr_none;
      $past(rd_isr) && !$past(wake_irq_out)
         |-> reg_rdata_out[0] == !$past(irq_out);
   endproperty
   property p_wake;
      clk_en_in && wake_in |=> wake_irq_out;
   endproperty
   property p_wake_irq;
      wake_irq_out |-> irq_out;
   endproperty
   property p_msr;
      ier_q[IER_MS] && msr_delta_in != 4'h0 |-> ##[0:1] irq_out;
   endproperty
   property p_rx_ready_irq;
      ier_q[IER_RX] && |rx_in.level && rx_in.level >= rx_in.trig
         |-> ##[0:1] irq_out;
   endproperty
   property p_lsr;
      $past(rd_lsr) |-> reg_rdata_out[0] == |$past(rx_in.level) &&
         reg_rdata_out[5:2] == {~|$past(tx_in.level), $past(rx_in.head_err)};
   endproperty
   property p_polled;
      ier_q == IER_RST && !wake_irq_out |-> !irq_out;
   endproperty
   a_rd_idle:   assert property (p_rd_idle)   else $error("rdata not idle");
   a_isr_fifo:  assert property (p_isr_fifo)  else $error("isr 7:6");
   a_isr_none:  assert property (p_isr_none)  else $error("isr b0");
   a_wake:      assert property (p_wake)      else $error("wake");
   a_wake_irq:  assert property (p_wake_irq)  else $error("wake irq");
   a_msr:       assert property (p_msr)       else $error("modem");
   a_rx_ready_irq:     assert property (p_rx_ready_irq)     else $error("rx ready");
   a_lsr:       assert property (p_lsr)       else $error("line stat");
   a_polled:    assert property (p_polled)    else $error("polled");
   c_isr:  cover property (rd_isr && irq_out);
   c_wake: cover property (wake_irq_out);
   c_tx:   cover property (irq_out && ier_q[IER_TX]);
endmodule : uie_top_chk
bind uie_top uie_top_chk u_chk (.mclk_in, .rst_n_in, .clk_en_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .rx_in, .tx_in, .msr_delta_in, .wake_in, .irq_out, .wake_irq_out,
   .fifo_en_out);
`default_nettype wire

// [verilog/uie_pkg.sv]
package uie_pkg;

   // -------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int LVL_W  = 9;
   localparam int TMO_W  = 6;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_IER = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_ISR = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_LSR = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_CFG = 4'h8;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [DATA_W-1:0] IER_RST = 8'h00;
   localparam logic [DATA_W-1:0] CFG_RST = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

   // -------------------------------------------------------------
   // Enable register fields
   // -------------------------------------------------------------
   localparam int IER_RX   = 0;
   localparam int IER_TX   = 1;
   localparam int IER_LS   = 2;
   localparam int IER_MS   = 3;
   localparam int IER_XOFF = 5;
   localparam int IER_RTS  = 6;
   localparam int IER_CTS  = 7;

   // -------------------------------------------------------------
   // Configuration register fields
   // -------------------------------------------------------------
   localparam int CFG_FIFO_EN  = 0;
   localparam int CFG_ENH      = 1;
   localparam int CFG_AUTO_RTS = 2;
   localparam int CFG_AUTO_CTS = 3;
   localparam int CFG_SEL_DSR  = 4;
   localparam int CFG_RS485    = 5;
   localparam int CFG_USED_W   = 6;

   // -------------------------------------------------------------
   // Status codes, bits 5:0
   // -------------------------------------------------------------
   localparam logic [5:0] ISR_LS   = 6'h06;
   localparam logic [5:0] ISR_RXRD = 6'h04;
   localparam logic [5:0] ISR_TMO  = 6'h0C;
   localparam logic [5:0] ISR_TX   = 6'h02;
   localparam logic [5:0] ISR_MS   = 6'h00;
   localparam logic [5:0] ISR_XCH  = 6'h10;
   localparam logic [5:0] ISR_CHG  = 6'h20;
   localparam logic [5:0] ISR_NONE = 6'h01;

   // -------------------------------------------------------------
   // Receive time-out: characters plus extra bit times
   // -------------------------------------------------------------
   localparam int TMO_CHARS      = 4;
   localparam int TMO_EXTRA_BITS = 12;
   localparam int FRAME_BASE     = 7;

   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic             push;
      logic             push_err;
      logic             pop;
      logic             overrun;
      logic [2:0]       head_err;
      logic             any_err;
      logic [LVL_W-1:0] level;
      logic [LVL_W-1:0] trig;
   } uie_rx_t;

   typedef struct packed {
      logic [LVL_W-1:0] level;
      logic [LVL_W-1:0] trig;
      logic             shift_empty;
   } uie_tx_t;

   typedef struct packed {
      logic xoff;
      logic xon;
      logic special;
   } uie_flow_t;

   typedef struct packed {
      logic msr_read;
      logic rhr_read;
      logic thr_write;
      logic summary_read;
   } uie_acc_t;

   typedef enum logic [1:0] {
      TMO_IDLE,
      TMO_RUN,
      TMO_DONE
   } uie_tmo_t;

endpackage : uie_pkg

// [verilog/uie_top.sv]
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - FIFO mode: receive-ready pending while RX level at or above trigger.
// - Data-ready status set when RX holds a character, clear when empty.
// - FIFO enabled with low enables zero gives polled mode: no line, data, time-out, TX or modem interrupts.
// - Line status: ready, overrun, head errors, TX empty, all empty, FIFO error.
// - Enhanced mode and enable 7: CTS rising edge raises change interrupt.
// - Enhanced mode and enable 6: RTS rising edge raises change interrupt.
// - Enhanced mode and enable 5: received Xoff raises interrupt; bit 4 reserved.
// - Enable 3: modem interrupt while any modem delta bit is set.
// - Enable 2: line interrupt on error character, again when it reaches head.
// - Error bits show only the head byte; bit 7 covers the whole FIFO.
// - TX interrupt on empty, or below trigger then empty; RS-485 waits shifter.
// - Enable 0: receive-ready on holding data or FIFO trigger level.
// - Status read returns highest pending level; others stay queued.
// - Priority codes: line 1, data 2, time-out 3, TX 4, modem 5; none 01.
// - Xon/Xoff/special level 6 sets bit 4; pin change level 7 sets bit 5.
// - Receive time-out after four character times plus twelve bit times.
// - Auto CTS/DSR: selected input rising raises change interrupt.
// - Auto RTS/DTR: selected output rising raises change interrupt.
// - Wake-up raises interrupt; summary register read clears it.
// - Line read, holding read, level drop and modem read clear their sources.
// - Status read or TX write clears TX; status read clears flow characters.
// - Status bits 7:6 read 11 with FIFOs enabled, 00 otherwise.
// - Status bit 0 low while pending, high when nothing pending or only wake-up pending.
module uie_top (
   input  wire logic                      mclk_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      clk_en_in,
   input  wire logic [uie_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [uie_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   output logic      [uie_pkg::DATA_W-1:0] reg_rdata_out,
   input  wire uie_pkg::uie_rx_t          rx_in,
   input  wire uie_pkg::uie_tx_t          tx_in,
   input  wire uie_pkg::uie_flow_t        flow_in,
   input  wire uie_pkg::uie_acc_t         acc_in,
   input  wire logic [3:0]                msr_delta_in,
   input  wire logic                      cts_in,
   input  wire logic                      dsr_in,
   input  wire logic                      rts_in,
   input  wire logic                      dtr_in,
   input  wire logic                      wake_in,
   input  wire logic                      bit_tick_in,
   input  wire logic [1:0]                word_len_in,
   output logic                           irq_out,
   output logic                           wake_irq_out,
   output logic                           fifo_en_out
);
   import uie_pkg::*;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction : rise

   function automatic logic below(input logic [LVL_W-1:0] lvl,
                                  input logic [LVL_W-1:0] trg);
      below = (lvl < trg);
   endfunction : below

   // -------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------
   logic [DATA_W-1:0] ier_reg;
   logic [DATA_W-1:0] cfg_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic              ls_pend_reg;
   logic              ovr_reg;
   logic              tx_pend_reg;
   logic              xch_pend_reg;
   logic              chg_pend_reg;
   logic              wake_reg;
   logic              tmo_pend_reg;
   uie_tmo_t          tmo_state_reg;
   logic [TMO_W-1:0]  tmo_cnt_reg;
   logic              tx_below_reg;
   logic              tx_empty_reg;
   logic              cts_reg;
   logic              dsr_reg;
   logic              rts_reg;
   logic              dtr_reg;

   logic              fifo_en;
   logic              enh;
   logic              wr_ier;
   logic              wr_cfg;
   logic              rd_isr;
   logic              rd_lsr;
   logic [5:0]        isr_code;
   logic [DATA_W-1:0] isr_val;
   logic [DATA_W-1:0] lsr_val;
   logic              rx_ready;
   logic              tx_empty_src;
   logic              tx_below;
   logic              tx_set;
   logic              ls_set;
   logic              xch_set;
   logic              chg_set;
   logic              ms_pend;
   logic [TMO_W-1:0]  tmo_limit;

   assign fifo_en = cfg_reg[CFG_FIFO_EN];
   assign enh     = cfg_reg[CFG_ENH];
   assign wr_ier  = reg_wr_in && (reg_addr_in == OFS_IER);
   assign wr_cfg  = reg_wr_in && (reg_addr_in == OFS_CFG);
   assign rd_isr  = reg_rd_in && (reg_addr_in == OFS_ISR);
   assign rd_lsr  = reg_rd_in && (reg_addr_in == OFS_LSR);

   // -------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ier_reg <= IER_RST;
      end else if (clk_en_in && wr_ier) begin
         ier_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_reg <= CFG_RST;
      end else if (clk_en_in && wr_cfg) begin
         cfg_reg <= {{(DATA_W-CFG_USED_W){1'b0}},
                     reg_wdata_in[CFG_USED_W-1:0]};
      end
   end

   // -------------------------------------------------------------
   // Receive data ready
   // -------------------------------------------------------------
   // Level source: follows the FIFO, so it drops by itself once
   // software reads below the trigger.
   always_comb begin
      if (fifo_en) begin
         rx_ready = !below(rx_in.level, rx_in.trig);
      end else begin
         rx_ready = (rx_in.level != '0);
      end
   end

   // -------------------------------------------------------------
   // Receive time-out
   // -------------------------------------------------------------
   // Frame bits are start, data and one stop: 7 with five data bits; word length adds 0..3.
   assign tmo_limit = TMO_W'(TMO_CHARS * (FRAME_BASE + int'(word_len_in))
                             + TMO_EXTRA_BITS);

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmo_state_reg <= TMO_IDLE;
         tmo_cnt_reg   <= '0;
      end else if (clk_en_in) begin
         case (tmo_state_reg)
            TMO_IDLE: begin
               tmo_cnt_reg <= '0;
               if (fifo_en && rx_in.level != '0) begin
                  tmo_state_reg <= TMO_RUN;
               end
            end
            TMO_RUN: begin
               if (!fifo_en || rx_in.level == '0) begin
                  tmo_state_reg <= TMO_IDLE;
               end else if (rx_in.push || acc_in.rhr_read) begin
                  tmo_cnt_reg <= '0;
               end else if (bit_tick_in) begin
                  if (tmo_cnt_reg + 1'b1 >= tmo_limit) begin
                     tmo_state_reg <= TMO_DONE;
                  end
                  tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
               end
            end
            TMO_DONE: begin
               // Rearms only on fresh activity, not on a stale FIFO
               tmo_cnt_reg <= '0;
               if (!fifo_en || rx_in.level == '0) begin
                  tmo_state_reg <= TMO_IDLE;
               end else if (rx_in.push || acc_in.rhr_read) begin
                  tmo_state_reg <= TMO_RUN;
               end
            end
            default: begin
               tmo_state_reg <= TMO_IDLE;
               tmo_cnt_reg   <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmo_pend_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (tmo_state_reg == TMO_RUN && bit_tick_in
             && !(rx_in.push || acc_in.rhr_read)
             && rx_in.level != '0
             && tmo_cnt_reg + 1'b1 >= tmo_limit) begin
            tmo_pend_reg <= 1'b1;
         end else if (acc_in.rhr_read || !fifo_en) begin
            tmo_pend_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Line status
   // -------------------------------------------------------------
   // Second raise when a bad byte becomes the head after a pop.
   assign ls_set = (rx_in.push && rx_in.push_err)
                 || rx_in.overrun
                 || (rx_in.pop && rx_in.head_err != '0);

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ls_pend_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (ls_set) begin
            ls_pend_reg <= 1'b1;
         end else if (rd_lsr) begin
            ls_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ovr_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (rx_in.overrun) begin
            ovr_reg <= 1'b1;
         end else if (rd_lsr) begin
            ovr_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      lsr_val    = RD_ZERO;
      lsr_val[0] = (rx_in.level != '0);
      lsr_val[1] = ovr_reg;
      lsr_val[4:2] = rx_in.head_err;
      lsr_val[5] = (tx_in.level == '0);
      lsr_val[6] = (tx_in.level == '0) && tx_in.shift_empty;
      lsr_val[7] = fifo_en && rx_in.any_err;
   end

   // -------------------------------------------------------------
   // Transmit ready
   // -------------------------------------------------------------
   // Under RS-485 the empty event waits for the shifter as well, so
   // the direction pin is not turned before the last stop bit.
   assign tx_empty_src = (tx_in.level == '0)
                       && (!cfg_reg[CFG_RS485] || tx_in.shift_empty);
   assign tx_below     = below(tx_in.level, tx_in.trig);

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_below_reg <= 1'b1;
         tx_empty_reg <= 1'b1;
      end else if (clk_en_in) begin
         tx_below_reg <= tx_below;
         tx_empty_reg <= tx_empty_src;
      end
   end

   always_comb begin
      if (fifo_en) begin
         tx_set = rise(tx_below_reg, tx_below)
                || rise(tx_empty_reg, tx_empty_src);
      end else begin
         tx_set = rise(tx_empty_reg, tx_empty_src);
      end
   end

   // -------------------------------------------------------------
   // Modem, flow characters, pin changes
   // -------------------------------------------------------------
   assign ms_pend = (msr_delta_in != 4'h0);

   assign xch_set = (flow_in.xoff && enh && ier_reg[IER_XOFF])
                  || (enh && ier_reg[IER_XOFF]
                      && (flow_in.xon || flow_in.special));

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cts_reg <= 1'b0;
         dsr_reg <= 1'b0;
         rts_reg <= 1'b0;
         dtr_reg <= 1'b0;
      end else if (clk_en_in) begin
         cts_reg <= cts_in;
         dsr_reg <= dsr_in;
         rts_reg <= rts_in;
         dtr_reg <= dtr_in;
      end
   end

   always_comb begin
      chg_set = 1'b0;
      if (enh && ier_reg[IER_CTS] && rise(cts_reg, cts_in)) begin
         chg_set = 1'b1;
      end
      if (enh && ier_reg[IER_RTS] && rise(rts_reg, rts_in)) begin
         chg_set = 1'b1;
      end
      if (cfg_reg[CFG_AUTO_CTS]) begin
         if (cfg_reg[CFG_SEL_DSR] ? rise(dsr_reg, dsr_in)
                                  : rise(cts_reg, cts_in)) begin
            chg_set = 1'b1;
         end
      end
      if (cfg_reg[CFG_AUTO_RTS]) begin
         if (cfg_reg[CFG_SEL_DSR] ? rise(dtr_reg, dtr_in)
                                  : rise(rts_reg, rts_in)) begin
            chg_set = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // Priority encoding
   // -------------------------------------------------------------
   // Line, data, time-out, TX and modem sources compete only when enabled; flow and pin-change pending bits are not masked.
   always_comb begin
      if (ier_reg[IER_LS] && ls_pend_reg) begin
         isr_code = ISR_LS;
      end else if (ier_reg[IER_RX] && rx_ready) begin
         isr_code = ISR_RXRD;
      end else if (ier_reg[IER_RX] && tmo_pend_reg) begin
         isr_code = ISR_TMO;
      end else if (ier_reg[IER_TX] && tx_pend_reg) begin
         isr_code = ISR_TX;
      end else if (ier_reg[IER_MS] && ms_pend) begin
         isr_code = ISR_MS;
      end else if (xch_pend_reg) begin
         isr_code = ISR_XCH;
      end else if (chg_pend_reg) begin
         isr_code = ISR_CHG;
      end else begin
         isr_code = ISR_NONE;
      end
   end

   assign isr_val = {fifo_en, fifo_en, isr_code};

   // -------------------------------------------------------------
   // Sticky sources cleared by status read, modem read or summary read
   // -------------------------------------------------------------
   // A status read clears only the level it actually reported.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_pend_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (tx_set) begin
            tx_pend_reg <= 1'b1;
         end else if (acc_in.thr_write
                      || (rd_isr && isr_code == ISR_TX)) begin
            tx_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xch_pend_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (xch_set) begin
            xch_pend_reg <= 1'b1;
         end else if (rd_isr && isr_code == ISR_XCH) begin
            xch_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chg_pend_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (chg_set) begin
            chg_pend_reg <= 1'b1;
         end else if (acc_in.msr_read) begin
            chg_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (wake_in) begin
            wake_reg <= 1'b1;
         end else if (acc_in.summary_read) begin
            wake_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   always_comb begin
      rdata_next = RD_ZERO;
      if (reg_rd_in) begin
         case (reg_addr_in)
            OFS_IER: rdata_next = ier_reg;
            OFS_ISR: rdata_next = isr_val;
            OFS_LSR: rdata_next = lsr_val;
            OFS_CFG: rdata_next = cfg_reg;
            default: rdata_next = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= RD_ZERO;
      end else if (clk_en_in) begin
         rdata_reg <= rdata_next;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign reg_rdata_out = rdata_reg;
   assign irq_out       = (isr_code != ISR_NONE) || wake_reg;
   assign wake_irq_out  = wake_reg;
   assign fifo_en_out   = fifo_en;

endmodule : uie_top

`default_nettype wire
